// >>> hdl/ssr_pkg.sv
/*
 Constants for the scratch-register access controller: command encodings,
 mode-register field positions, format codes and timing counts.
 Assumes a 250 MHz core clock; the memory clock is half of it.
*/
`default_nettype none
package ssr_pkg;
	localparam int CORE_NS = 4;
	// Timing figures in ns (plain defaults), and core-cycle counts rounded up
	localparam int TRP_NS = 15;
	localparam int MODE_SET_COMMAND_DELAY_NS = 64;
	localparam int MODE_SET_UPDATE_DELAY_NS = 192;
	localparam int SCRATCH_WRITE_RECOVERY_TIME_NS = 120;
	localparam int SCRATCH_EXIT_RECOVERY_TIME_NS = 8;
	localparam int TCCD_NS = 32;
	localparam int TRP_CYC = (TRP_NS + CORE_NS - 1) / CORE_NS;
	localparam int MODE_SET_COMMAND_DELAY_CYC = (MODE_SET_COMMAND_DELAY_NS + CORE_NS - 1) / CORE_NS;
	localparam int MODE_SET_UPDATE_DELAY_CYC = (MODE_SET_UPDATE_DELAY_NS + CORE_NS - 1) / CORE_NS;
	localparam int TMODE_CYC = (MODE_SET_UPDATE_DELAY_CYC > MODE_SET_COMMAND_DELAY_CYC) ? MODE_SET_UPDATE_DELAY_CYC : MODE_SET_COMMAND_DELAY_CYC;
	localparam int TWR_CYC = (SCRATCH_WRITE_RECOVERY_TIME_NS + CORE_NS - 1) / CORE_NS;
	localparam int SCRATCH_EXIT_RECOVERY_TIME_CYC = (SCRATCH_EXIT_RECOVERY_TIME_NS + CORE_NS - 1) / CORE_NS;
	localparam int TCCD_CYC = (TCCD_NS + CORE_NS - 1) / CORE_NS;
	// Input synchroniser depth and the extra cycle until the clock rises
	localparam int CAP_FIXED_CYC = 3;
	// Command codes as {ras_n, cas_n, we_n} with chip select low
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_WR = 3'h4;
	localparam logic [2:0] CMD_RD = 3'h5;
	localparam logic [2:0] CMD_IDLE = 3'h7;
	// Mode register three selection and field positions
	localparam logic [1:0] MR3_BG = 2'h0;
	localparam logic [1:0] MR3_BA = 2'h3;
	localparam int MR3_EN_BIT = 2;
	localparam int MR3_FMT_LSB = 11;
	localparam int A10_BIT = 10;
	localparam int A12_BIT = 12;
	// Read-out format codes
	localparam logic [1:0] FMT_SERIAL = 2'h0;
	localparam logic [1:0] FMT_PARALLEL = 2'h1;
	localparam logic [1:0] FMT_STAGGER = 2'h2;
	localparam logic [1:0] PAGE_ZERO = 2'h0;
	localparam logic [1:0] LOC_ZERO = 2'h0;
	// Burst-length field of mode register zero that needs A12 high
	localparam logic [1:0] BL_OTF = 2'h1;
	// User operations
	localparam logic [1:0] OP_ENTER = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_EXIT = 2'h3;
endpackage
`default_nettype wire

// >>> hdl/ssr_ctrl.sv
/*
 Controller that drives a DDR4 device's command pins to enter scratch
 access, write and read scratch locations, and leave scratch access.
 Assumes the device samples pins on the rising edge of o_ck, which is the
 core clock divided by two, and returns read data on DQ one beat per
 core cycle after the read latency.
*/
// Summary of operation
// - Parallel format reads are addressed to location 0 only.
// - Reads drive A[1:0]=00 and A2=0.
// - Reads drive A12 high when the burst-length field is 01.
// - A write stores A[7:0] into page 0, bit i to beat i.
// - No data bus inversion during scratch writes.
// - Before access: DLL lock, precharge all, wait, enable, wait mode delays.
// - Writes only while page 0 is selected.
// - Bank address bits pick the location; other address bits ignored.
// - Wait the write recovery time after each scratch write.
// - Wait exit recovery, clear enable, wait before array commands.
// - Format field codes: 00 serial, 01 parallel, 10 staggered.
`default_nettype none
module ssr_ctrl #(
	parameter int DQ_W = 8,
	parameter int RL_CK = 16
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_cmd_valid,
	input wire logic [1:0] i_cmd_op,
	input wire logic [1:0] i_cmd_loc,
	input wire logic [7:0] i_cmd_data,
	input wire logic [1:0] i_fmt,
	input wire logic [1:0] i_page,
	input wire logic [1:0] i_bl_field,
	input wire logic i_pl_en,
	input wire logic [3:0] i_pl,
	input wire logic i_dll_en,
	input wire logic i_dll_locked,
	input wire logic [DQ_W-1:0] i_dq,
	output logic o_cmd_ready,
	output logic o_err,
	output logic o_in_mode,
	output logic o_rd_valid,
	output logic [8*DQ_W-1:0] o_rd_data,
	output logic o_ck,
	output logic o_cs_n,
	output logic o_act_n,
	output logic o_ras_n,
	output logic o_cas_n,
	output logic o_we_n,
	output logic [1:0] o_bg,
	output logic [1:0] o_ba,
	output logic [13:0] o_addr
);
	typedef enum logic [3:0] {
		SSR_IDLE, SSR_DLL, SSR_PRE, SSR_PREW, SSR_MRS_ON, SSR_WAIT,
		SSR_WR, SSR_RD, SSR_CAP, SSR_XWAIT, SSR_MRS_OFF
	} ssr_state_e;

	ssr_state_e state_reg, state_next;
	logic [15:0] wait_reg, wait_next;
	logic mode_reg, mode_next;
	logic [1:0] fmt_reg, fmt_next, page_reg, page_next, loc_reg, loc_next;
	logic [7:0] data_reg, data_next;
	logic err_next;
	logic issue;
	logic [2:0] icmd;
	logic [1:0] iba, ibg;
	logic [13:0] iaddr;
	logic cap_start;
	logic ck_reg, cs_n_reg;
	logic [2:0] cmd_reg;
	logic [1:0] ba_reg, bg_reg;
	logic [13:0] addr_reg;
	logic ready_reg, err_reg, rd_valid_reg;
	logic [DQ_W-1:0] dq_s1_reg, dq_s2_reg;
	logic cap_busy_reg;
	logic [15:0] cap_cnt_reg;
	logic [2:0] beat_reg;
	logic [8*DQ_W-1:0] shift_reg, rd_data_reg;

	wire phase = ck_reg;
	wire take = i_cmd_valid & ready_reg & (state_reg == SSR_IDLE);
	wire wait_done = (wait_reg == 16'h0000);
	wire [15:0] wait_dec = wait_done ? 16'h0000 : wait_reg - 16'h0001;
	wire [3:0] pl_add = i_pl_en ? i_pl : 4'h0;
	wire [15:0] cap_lat = 16'(2 * (RL_CK + int'(pl_add)) + ssr_pkg::CAP_FIXED_CYC);
	wire rd_a12 = (i_bl_field == ssr_pkg::BL_OTF);
	wire par_bad = (fmt_reg == ssr_pkg::FMT_PARALLEL) && (i_cmd_loc != ssr_pkg::LOC_ZERO);
	wire page_bad = (page_reg != ssr_pkg::PAGE_ZERO);

	always_comb begin
		state_next = state_reg;
		wait_next = wait_dec;
		mode_next = mode_reg;
		fmt_next = fmt_reg;
		page_next = page_reg;
		loc_next = loc_reg;
		data_next = data_reg;
		err_next = 1'b0;
		issue = 1'b0;
		icmd = ssr_pkg::CMD_IDLE;
		iba = 2'h0;
		ibg = 2'h0;
		iaddr = 14'h0000;
		cap_start = 1'b0;
		unique case (state_reg)
			SSR_IDLE: begin
				if (take) begin
					unique case (i_cmd_op)
						ssr_pkg::OP_ENTER: begin
							if (mode_reg) begin
								err_next = 1'b1;
							end else begin
								fmt_next = i_fmt;
								page_next = i_page;
								state_next = SSR_DLL;
							end
						end
						ssr_pkg::OP_WRITE: begin
							if (!mode_reg || page_bad) begin
								err_next = 1'b1;
							end else begin
								loc_next = i_cmd_loc;
								data_next = i_cmd_data;
								state_next = SSR_WR;
							end
						end
						ssr_pkg::OP_READ: begin
							if (!mode_reg || par_bad) begin
								err_next = 1'b1;
							end else begin
								loc_next = i_cmd_loc;
								state_next = SSR_RD;
							end
						end
						ssr_pkg::OP_EXIT: begin
							if (!mode_reg) begin
								err_next = 1'b1;
							end else begin
								wait_next = 16'(ssr_pkg::SCRATCH_EXIT_RECOVERY_TIME_CYC);
								state_next = SSR_XWAIT;
							end
						end
					endcase
				end
			end
			SSR_DLL: begin
				if (!i_dll_en || i_dll_locked) begin
					state_next = SSR_PRE;
				end
			end
			SSR_PRE: begin
				if (phase) begin
					issue = 1'b1;
					icmd = ssr_pkg::CMD_PRE;
					iaddr[ssr_pkg::A10_BIT] = 1'b1;
					wait_next = 16'(ssr_pkg::TRP_CYC);
					state_next = SSR_PREW;
				end
			end
			SSR_PREW: begin
				if (wait_done) begin
					state_next = SSR_MRS_ON;
				end
			end
			SSR_MRS_ON: begin
				if (phase) begin
					issue = 1'b1;
					icmd = ssr_pkg::CMD_MRS;
					ibg = ssr_pkg::MR3_BG;
					iba = ssr_pkg::MR3_BA;
					iaddr[ssr_pkg::MR3_EN_BIT] = 1'b1;
					iaddr[ssr_pkg::MR3_FMT_LSB+:2] = fmt_reg;
					iaddr[1:0] = page_reg;
					mode_next = 1'b1;
					wait_next = 16'(ssr_pkg::TMODE_CYC);
					state_next = SSR_WAIT;
				end
			end
			SSR_WAIT: begin
				if (wait_done) begin
					state_next = SSR_IDLE;
				end
			end
			SSR_WR: begin
				if (phase) begin
					issue = 1'b1;
					icmd = ssr_pkg::CMD_WR;
					iba = loc_reg;
					iaddr[7:0] = data_reg;
					wait_next = 16'(ssr_pkg::TWR_CYC);
					state_next = SSR_WAIT;
				end
			end
			SSR_RD: begin
				if (phase) begin
					issue = 1'b1;
					icmd = ssr_pkg::CMD_RD;
					iba = loc_reg;
					iaddr[2:0] = 3'h0;
					iaddr[ssr_pkg::A12_BIT] = rd_a12;
					cap_start = 1'b1;
					wait_next = 16'(ssr_pkg::TCCD_CYC);
					state_next = SSR_CAP;
				end
			end
			SSR_CAP: begin
				if (wait_done && !cap_busy_reg) begin
					state_next = SSR_IDLE;
				end
			end
			SSR_XWAIT: begin
				if (wait_done) begin
					state_next = SSR_MRS_OFF;
				end
			end
			SSR_MRS_OFF: begin
				if (phase) begin
					issue = 1'b1;
					icmd = ssr_pkg::CMD_MRS;
					ibg = ssr_pkg::MR3_BG;
					iba = ssr_pkg::MR3_BA;
					mode_next = 1'b0;
					wait_next = 16'(ssr_pkg::TMODE_CYC);
					state_next = SSR_WAIT;
				end
			end
			default: begin
				state_next = SSR_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= SSR_IDLE;
			wait_reg <= 16'h0000;
			mode_reg <= 1'b0;
			fmt_reg <= ssr_pkg::FMT_SERIAL;
			page_reg <= ssr_pkg::PAGE_ZERO;
			loc_reg <= 2'h0;
			data_reg <= 8'h00;
			ready_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			wait_reg <= wait_next;
			mode_reg <= mode_next;
			fmt_reg <= fmt_next;
			page_reg <= page_next;
			loc_reg <= loc_next;
			data_reg <= data_next;
			ready_reg <= (state_next == SSR_IDLE);
			err_reg <= err_next;
		end
	end

	// Pins change only as the divided clock falls, so they are centred on its rise
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ck_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			cmd_reg <= ssr_pkg::CMD_IDLE;
			ba_reg <= 2'h0;
			bg_reg <= 2'h0;
			addr_reg <= 14'h0000;
		end else begin
			ck_reg <= ~ck_reg;
			if (phase) begin
				cs_n_reg <= ~issue;
				cmd_reg <= icmd;
				ba_reg <= iba;
				bg_reg <= ibg;
				addr_reg <= iaddr;
			end
		end
	end

	// Read data capture; DQ is only ever received, write data rides on the address pins
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dq_s1_reg <= '0;
			dq_s2_reg <= '0;
			cap_busy_reg <= 1'b0;
			cap_cnt_reg <= 16'h0000;
			beat_reg <= 3'h0;
			shift_reg <= '0;
			rd_data_reg <= '0;
			rd_valid_reg <= 1'b0;
		end else begin
			dq_s1_reg <= i_dq;
			dq_s2_reg <= dq_s1_reg;
			rd_valid_reg <= 1'b0;
			if (cap_start) begin
				cap_busy_reg <= 1'b1;
				cap_cnt_reg <= cap_lat;
				beat_reg <= 3'h0;
			end else if (cap_busy_reg) begin
				if (cap_cnt_reg != 16'h0000) begin
					cap_cnt_reg <= cap_cnt_reg - 16'h0001;
				end else begin
					shift_reg <= {dq_s2_reg, shift_reg[8*DQ_W-1:DQ_W]};
					beat_reg <= beat_reg + 3'h1;
					if (beat_reg == 3'h7) begin
						cap_busy_reg <= 1'b0;
						rd_valid_reg <= 1'b1;
						rd_data_reg <= {dq_s2_reg, shift_reg[8*DQ_W-1:DQ_W]};
					end
				end
			end
		end
	end

	assign o_cmd_ready = ready_reg;
	assign o_err = err_reg;
	assign o_in_mode = mode_reg;
	assign o_rd_valid = rd_valid_reg;
	assign o_rd_data = rd_data_reg;
	assign o_ck = ck_reg;
	assign o_cs_n = cs_n_reg;
	assign o_act_n = 1'b1;
	assign o_ras_n = cmd_reg[2];
	assign o_cas_n = cmd_reg[1];
	assign o_we_n = cmd_reg[0];
	assign o_bg = bg_reg;
	assign o_ba = ba_reg;
	assign o_addr = addr_reg;

	// Checking helpers: cycles since the previous command and what it was
	logic [15:0] gap_reg;
	logic [2:0] last_cmd_reg;
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			gap_reg <= 16'hffff;
			last_cmd_reg <= ssr_pkg::CMD_IDLE;
		end else if (issue) begin
			gap_reg <= 16'h0001;
			last_cmd_reg <= icmd;
		end else if (gap_reg != 16'hffff) begin
			gap_reg <= gap_reg + 16'h0001;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	sequence s_iss_rd;
		issue && (icmd == ssr_pkg::CMD_RD);
	endsequence
	sequence s_iss_wr;
		issue && (icmd == ssr_pkg::CMD_WR);
	endsequence
	sequence s_iss_on;
		issue && (icmd == ssr_pkg::CMD_MRS) && iaddr[ssr_pkg::MR3_EN_BIT];
	endsequence
	sequence s_iss_off;
		issue && (icmd == ssr_pkg::CMD_MRS) && !iaddr[ssr_pkg::MR3_EN_BIT];
	endsequence

	AST_RD_ADDR: assert property (s_iss_rd |=> (o_addr[2:0] == 3'h0) [*2])
		else $error("scratch read with nonzero low column bits");
	AST_RD_A12: assert property (s_iss_rd ##1 1'b1 |-> o_addr[ssr_pkg::A12_BIT] == $past(rd_a12))
		else $error("A12 does not follow the burst-length field");
	AST_PAR_LOC: assert property (s_iss_rd and (fmt_reg == ssr_pkg::FMT_PARALLEL) |=> o_ba == 2'h0)
		else $error("parallel format read to a location other than zero");
	AST_WR_PAGE: assert property (s_iss_wr |-> page_reg == ssr_pkg::PAGE_ZERO)
		else $error("scratch write while a page other than zero is selected");
	AST_WR_PINS: assert property (s_iss_wr |=> !o_cs_n && !o_cas_n && (o_addr[7:0] == data_reg) && (o_ba == loc_reg))
		else $error("write data or location not on the pins");
	AST_WR_REC: assert property (issue && (last_cmd_reg == ssr_pkg::CMD_WR) |-> gap_reg >= 16'(ssr_pkg::TWR_CYC))
		else $error("command issued before write recovery elapsed");
	AST_ENTER_SEQ: assert property (s_iss_on |-> (last_cmd_reg == ssr_pkg::CMD_PRE) && (gap_reg >= 16'(ssr_pkg::TRP_CYC)))
		else $error("scratch enable not preceded by a timed precharge");
	AST_EXIT_WAIT: assert property (s_iss_off |-> gap_reg >= 16'(ssr_pkg::SCRATCH_EXIT_RECOVERY_TIME_CYC))
		else $error("scratch disable issued before exit recovery");
	AST_EXIT_MODE: assert property (s_iss_off |=> !mode_reg ##1 !ready_reg [*4])
		else $error("controller ready too soon after scratch disable");
	AST_RD_DONE: assert property (s_iss_rd |-> ##[8:300] rd_valid_reg)
		else $error("read burst never captured");
endmodule
`default_nettype wire

// >>> sim/ssr_dev_model.sv
/*
 Behavioural model of the memory device's scratch access path.
 Assumes pins are stable at each o_ck rise and DQ changes once per core cycle.
*/
`default_nettype none
module ssr_dev_model #(
	parameter int DQ_W = 8,
	parameter int RL_CK = 4
) (
	input wire logic i_core_clk,
	input wire logic i_ck,
	input wire logic i_cs_n,
	input wire logic i_ras_n,
	input wire logic i_cas_n,
	input wire logic i_we_n,
	input wire logic [1:0] i_ba,
	input wire logic [13:0] i_addr,
	input wire logic [3:0] i_pl_add,
	output logic [DQ_W-1:0] o_dq
);
	timeunit 1ns;
	timeprecision 1ps;
	// Power-up pattern values are arbitrary
	logic [7:0] mem [4] = '{8'h55, 8'h33, 8'h0f, 8'h00};
	logic en = 1'b0;
	logic [1:0] fmt = 2'h0;
	logic [1:0] page = 2'h0;
	logic [1:0] rd_loc = 2'h0;
	logic [13:0] rd_addr = 14'h0;
	int n_pre = 0;
	int rd_cnt = 0;
	int seen = 0;
	int t = 0;
	int lat = 1;
	int e;
	wire [2:0] cmd = {i_ras_n, i_cas_n, i_we_n};
	initial o_dq = '0;
	function automatic logic [DQ_W-1:0] beat(input int b);
		logic [DQ_W-1:0] v;
		for (int k = 0; k < DQ_W; k++) begin
			case (fmt)
				ssr_pkg::FMT_PARALLEL: v[k] = mem[0][k % 8];
				ssr_pkg::FMT_STAGGER: v[k] = mem[(rd_loc + k % 4) % 4][b];
				default: v[k] = mem[rd_loc][b];
			endcase
		end
		return v;
	endfunction
	always @(posedge i_ck) begin
		if (!i_cs_n) begin
			case (cmd)
				ssr_pkg::CMD_PRE: n_pre <= n_pre + 1;
				ssr_pkg::CMD_MRS: if (i_ba == ssr_pkg::MR3_BA) begin
					en <= i_addr[ssr_pkg::MR3_EN_BIT];
					fmt <= i_addr[12:11];
					page <= i_addr[1:0];
				end
				ssr_pkg::CMD_WR: if (en && page == ssr_pkg::PAGE_ZERO) begin
					mem[i_ba] <= i_addr[7:0];
				end
				ssr_pkg::CMD_RD: if (en) begin
					rd_loc <= i_ba;
					rd_addr <= i_addr;
					// First beat lands read latency plus parity latency after the command edge
					lat <= 2 * (RL_CK + i_pl_add);
					rd_cnt <= rd_cnt + 1;
				end
				default: ;
			endcase
		end
	end
	// Outside a burst the lanes toggle so stale data never passes for a match
	always @(posedge i_core_clk) begin
		e = (rd_cnt != seen) ? 1 : ((t > 0) ? t + 1 : 0);
		seen <= rd_cnt;
		t <= e;
		if (e >= lat && e < lat + 8) o_dq <= beat(e - lat);
		else o_dq <= ~o_dq;
	end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
/*
 Self-checking bench for the scratch access controller with a device model.
 Assumes the controller makes the memory clock itself from the core clock.
*/
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DQ_W = 8;
	localparam int RL = 4;
	logic core_clk, rst_b = 0, cmd_valid = 0, pl_en = 0, dll_en = 1, dll_locked = 0;
	logic [1:0] cmd_op = 0, cmd_loc = 0, fmt = 0, page = 0, bl_field = 0;
	logic [7:0] cmd_data = 0;
	logic [3:0] pl = 4'h2;
	logic [DQ_W-1:0] dq;
	logic cmd_ready, err, in_mode, rd_valid, ck, cs_n, act_n, ras_n, cas_n, we_n;
	logic [8*DQ_W-1:0] rd_data;
	logic [1:0] bg, ba;
	logic [13:0] addr;
	logic [7:0] wd [4] = '{8'ha5, 8'h3c, 8'h0f, 8'h81};
	int num_errors = 0;
	int n_checks = 0;
	ssr_ctrl #(.DQ_W(DQ_W), .RL_CK(RL)) i_dut (.i_core_clk(core_clk), .i_rst_b(rst_b),
		.i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_loc(cmd_loc), .i_cmd_data(cmd_data),
		.i_fmt(fmt), .i_page(page), .i_bl_field(bl_field), .i_pl_en(pl_en), .i_pl(pl),
		.i_dll_en(dll_en), .i_dll_locked(dll_locked), .i_dq(dq), .o_cmd_ready(cmd_ready),
		.o_err(err), .o_in_mode(in_mode), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
		.o_ck(ck), .o_cs_n(cs_n), .o_act_n(act_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
		.o_we_n(we_n), .o_bg(bg), .o_ba(ba), .o_addr(addr));
	ssr_dev_model #(.DQ_W(DQ_W), .RL_CK(RL)) i_dev (.i_core_clk(core_clk), .i_ck(ck),
		.i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba),
		.i_addr(addr), .i_pl_add(pl_en ? pl : 4'h0), .o_dq(dq));
	initial begin
		core_clk = 0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	// One request: raise valid while ready is high, then wait for completion
	task automatic op(input logic [1:0] o, input int l, input logic [7:0] d, input logic ex);
		logic e;
		// A hang here is caught by the watchdog, which counts it as a mismatch
		while (cmd_ready !== 1'b1) @(negedge core_clk);
		cmd_op = o;
		cmd_loc = 2'(l);
		cmd_data = d;
		cmd_valid = 1;
		@(negedge core_clk);
		cmd_valid = 0;
		e = err;
		@(negedge core_clk);
		e = e | err;
		check(e === ex, "refusal flag");
		if (o == ssr_pkg::OP_READ && !ex) begin
			while (rd_valid !== 1'b1) @(negedge core_clk);
		end
		while (cmd_ready !== 1'b1) @(negedge core_clk);
	endtask
	function automatic logic [8*DQ_W-1:0] exp_rd(input logic [1:0] f, input int n);
		logic [8*DQ_W-1:0] w;
		for (int b = 0; b < 8; b++)
			for (int k = 0; k < DQ_W; k++)
				w[b*DQ_W+k] = (f == ssr_pkg::FMT_PARALLEL) ? wd[0][k % 8] :
					(f == ssr_pkg::FMT_STAGGER) ? wd[(n + k % 4) % 4][b] : wd[n][b];
		return w;
	endfunction
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		$display("wrong value at %0t: run timed out", $time);
		finish_test();
	end
	initial begin
		repeat (16) @(negedge core_clk);
		rst_b = 1;
		fork
			begin
				repeat (40) @(negedge core_clk);
				check(i_dev.n_pre == 0, "precharge before lock");
				dll_locked = 1;
			end
		join_none
		fmt = ssr_pkg::FMT_STAGGER;
		op(ssr_pkg::OP_ENTER, 0, 0, 0);
		check(in_mode === 1'b1 && i_dev.fmt === ssr_pkg::FMT_STAGGER, "enter");
		check(i_dev.n_pre > 0, "precharge issued");
		op(ssr_pkg::OP_ENTER, 0, 0, 1);
		for (int n = 0; n < 4; n++) begin
			op(ssr_pkg::OP_WRITE, n, wd[n], 0);
			check(i_dev.mem[n] === wd[n], "stored byte");
		end
		fmt = ssr_pkg::FMT_SERIAL;
		for (int n = 0; n < 4; n++) begin
			pl_en = (n == 2);
			bl_field = (n == 3) ? ssr_pkg::BL_OTF : 2'h0;
			op(ssr_pkg::OP_READ, n, 0, 0);
			check(rd_data === exp_rd(ssr_pkg::FMT_STAGGER, n), "staggered data");
			check(i_dev.rd_addr[2:0] === 3'h0, "read column bits");
			check(i_dev.rd_addr[12] === (n == 3), "read chop bit");
		end
		pl_en = 0;
		op(ssr_pkg::OP_EXIT, 0, 0, 0);
		check(in_mode === 1'b0 && i_dev.en === 1'b0, "exit");
		$display("test staggered done");
		op(ssr_pkg::OP_READ, 0, 0, 1);
		fmt = ssr_pkg::FMT_PARALLEL;
		op(ssr_pkg::OP_ENTER, 0, 0, 0);
		op(ssr_pkg::OP_READ, 0, 0, 0);
		check(rd_data === exp_rd(ssr_pkg::FMT_PARALLEL, 0), "parallel data");
		op(ssr_pkg::OP_READ, 1, 0, 1);
		op(ssr_pkg::OP_EXIT, 0, 0, 0);
		$display("test parallel done");
		fmt = ssr_pkg::FMT_SERIAL;
		op(ssr_pkg::OP_ENTER, 0, 0, 0);
		op(ssr_pkg::OP_READ, 3, 0, 0);
		check(rd_data === exp_rd(ssr_pkg::FMT_SERIAL, 3), "serial data");
		op(ssr_pkg::OP_EXIT, 0, 0, 0);
		$display("test serial done");
		page = 2'h1;
		op(ssr_pkg::OP_ENTER, 0, 0, 0);
		op(ssr_pkg::OP_WRITE, 0, 8'hff, 1);
		check(i_dev.mem[0] === wd[0], "write on page one");
		op(ssr_pkg::OP_EXIT, 0, 0, 0);
		$display("test page guard done");
		finish_test();
	end
endmodule
`default_nettype wire
